/* src/isetr_pkg.sv */
// package: register map, bit positions and bus carriers for the status event tree
package isetr_pkg;

  // register byte offsets
  localparam logic [7:0] STD_EVT_OFS   = 8'h00;
  localparam logic [7:0] STD_ENA_OFS   = 8'h04;
  localparam logic [7:0] OPR_EVT_OFS   = 8'h08;
  localparam logic [7:0] OPR_ENA_OFS   = 8'h0c;
  localparam logic [7:0] OPU_EVT_OFS   = 8'h10;
  localparam logic [7:0] OPU_ENA_OFS   = 8'h14;
  localparam logic [7:0] OPS_EVT_OFS   = 8'h18;
  localparam logic [7:0] OPS_ENA_OFS   = 8'h1c;
  localparam logic [7:0] QST_EVT_OFS   = 8'h20;
  localparam logic [7:0] QST_ENA_OFS   = 8'h24;
  localparam logic [7:0] SUMMARY_OFS   = 8'h28;
  localparam logic [7:0] CLEAR_ALL_OFS = 8'h2c;

  // standard event bit positions
  localparam int OPERATION_DONE_BIT  = 0;
  localparam int CONTROL_REQUEST_BIT = 1;
  localparam int EMPTY_READ_BIT      = 2;
  localparam int INTERNAL_FAULT_BIT  = 3;
  localparam int EXEC_FAULT_BIT      = 4;
  localparam int COMMAND_FAULT_BIT   = 5;
  localparam int USER_REQUEST_BIT    = 6;
  localparam int POWER_CYCLED_BIT    = 7;

  // rollup positions
  localparam int UNIT_ROLLUP_BIT    = 13;
  localparam int SUMMARY_ROLLUP_BIT = 1;

  // summary event positions
  localparam int CAL_BIT     = 0;
  localparam int MEAS_BIT    = 4;
  localparam int TRIG_BIT    = 5;
  localparam int ARM_BIT     = 6;
  localparam int FILTER_BIT  = 8;
  localparam int LIST_BIT    = 9;
  localparam int IDLE_BIT    = 10;

  // implemented-bit masks for the event registers, other positions read zero; enable registers keep every bit written
  localparam logic [7:0]  STD_MASK = 8'hfd;
  localparam logic [15:0] OPR_MASK = 16'h2000;
  localparam logic [15:0] OPU_MASK = 16'h0002;
  localparam logic [15:0] OPS_MASK = 16'h0771;
  localparam logic [15:0] QST_MASK = 16'h2000;

  localparam logic [7:0]  STD_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // device-side event pulses into the standard register
  typedef struct packed {
    logic operation_done;
    logic empty_read;
    logic internal_fault;
    logic exec_fault;
    logic syntax_fault;
    logic semantic_fault;
    logic trigger_in_message;
    logic user_request;
  } isetr_std_evt_t;

  // instrument activity conditions
  typedef struct packed {
    logic calibrating;
    logic measuring;
    logic wait_trigger;
    logic wait_arm;
    logic filter_ready;
    logic list_running;
    logic idle;
  } isetr_cond_t;

endpackage

/* src/isetr_event_tree.sv */
// status event tree with an axi4-lite register slave
`timescale 1ns/1ps
module isetr_event_tree
  import isetr_pkg::*;
(
  input  wire logic           i_mclk,
  input  wire logic           i_reset,
  input  wire isetr_std_evt_t i_std_evt,
  input  wire isetr_cond_t    i_cond,
  input  wire logic           i_quest_unit_sum,
  input  wire logic [7:0]     i_s_axi_awaddr,
  input  wire logic           i_s_axi_awvalid,
  output logic                o_s_axi_awready,
  input  wire logic [31:0]    i_s_axi_wdata,
  input  wire logic [3:0]     i_s_axi_wstrb,
  input  wire logic           i_s_axi_wvalid,
  output logic                o_s_axi_wready,
  output logic [1:0]          o_s_axi_bresp,
  output logic                o_s_axi_bvalid,
  input  wire logic           i_s_axi_bready,
  input  wire logic [7:0]     i_s_axi_araddr,
  input  wire logic           i_s_axi_arvalid,
  output logic                o_s_axi_arready,
  output logic [31:0]         o_s_axi_rdata,
  output logic [1:0]          o_s_axi_rresp,
  output logic                o_s_axi_rvalid,
  input  wire logic           i_s_axi_rready,
  output logic                o_std_summary,
  output logic                o_opr_summary,
  output logic                o_quest_summary
);

  logic [7:0]  std_evt_reg;
  logic [7:0]  std_ena_reg;
  logic [15:0] opr_evt_reg;
  logic [15:0] opr_ena_reg;
  logic [15:0] opu_evt_reg;
  logic [15:0] opu_ena_reg;
  logic [15:0] ops_evt_reg;
  logic [15:0] ops_ena_reg;
  logic [15:0] qst_evt_reg;
  logic [15:0] qst_ena_reg;
  logic        pon_pending_reg;

  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  logic [7:0]  std_set;
  logic [15:0] opr_set;
  logic [15:0] opu_set;
  logic [15:0] ops_set;
  logic [15:0] qst_set;
  logic        wr_fire;
  logic        rd_fire;
  logic        clear_all;
  logic        ops_sum;
  logic        opu_sum;
  logic        qst_sum;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a <= CLEAR_ALL_OFS) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic any_enabled(input logic [15:0] e, input logic [15:0] n);
    any_enabled = |(e & n);
  endfunction

  // ---------------- event sources ----------------
  always_comb begin
    std_set = 8'h00;
    std_set[OPERATION_DONE_BIT] = i_std_evt.operation_done;
    std_set[CONTROL_REQUEST_BIT] = 1'b0;
    std_set[EMPTY_READ_BIT]     = i_std_evt.empty_read;
    std_set[INTERNAL_FAULT_BIT] = i_std_evt.internal_fault;
    std_set[EXEC_FAULT_BIT]     = i_std_evt.exec_fault;
    std_set[COMMAND_FAULT_BIT]  = i_std_evt.syntax_fault
                                | i_std_evt.semantic_fault
                                | i_std_evt.trigger_in_message;
    std_set[USER_REQUEST_BIT]   = i_std_evt.user_request;
    std_set[POWER_CYCLED_BIT]   = pon_pending_reg;
  end

  always_comb begin
    ops_set = 16'h0000;
    ops_set[CAL_BIT]    = i_cond.calibrating;
    ops_set[MEAS_BIT]   = i_cond.measuring;
    ops_set[TRIG_BIT]   = i_cond.wait_trigger;
    ops_set[ARM_BIT]    = i_cond.wait_arm;
    ops_set[FILTER_BIT] = i_cond.filter_ready;
    ops_set[LIST_BIT]   = i_cond.list_running;
    ops_set[IDLE_BIT]   = i_cond.idle;
  end

  // summaries are combinational so a read-clear drops them at once
  assign ops_sum = any_enabled(ops_evt_reg, ops_ena_reg);
  assign opu_sum = any_enabled(opu_evt_reg, opu_ena_reg);
  assign qst_sum = any_enabled(qst_evt_reg, qst_ena_reg);

  always_comb begin
    opu_set = 16'h0000;
    opu_set[SUMMARY_ROLLUP_BIT] = ops_sum;
    opr_set = 16'h0000;
    opr_set[UNIT_ROLLUP_BIT] = opu_sum;
    qst_set = 16'h0000;
    qst_set[UNIT_ROLLUP_BIT] = i_quest_unit_sum;
  end

  assign o_std_summary   = |(std_evt_reg & std_ena_reg);
  assign o_opr_summary   = any_enabled(opr_evt_reg, opr_ena_reg);
  assign o_quest_summary = qst_sum;

  // ---------------- bus handshake ----------------
  assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign o_s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign o_s_axi_arready = !rvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = i_s_axi_arvalid && !rvalid_reg;
  assign clear_all = wr_fire && aw_addr_reg == CLEAR_ALL_OFS && w_strb_reg[0] && w_data_reg[0];

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (i_s_axi_awvalid && o_s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (i_s_axi_wvalid && o_s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= i_s_axi_wdata;
      w_strb_reg <= i_s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= known_addr(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp  = bresp_reg;

  // read data captured as the flags are cleared by the same read
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= known_addr(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (i_s_axi_araddr)
        STD_EVT_OFS: rdata_reg <= {24'h000000, std_evt_reg};
        STD_ENA_OFS: rdata_reg <= {24'h000000, std_ena_reg};
        OPR_EVT_OFS: rdata_reg <= {16'h0000, opr_evt_reg};
        OPR_ENA_OFS: rdata_reg <= {16'h0000, opr_ena_reg};
        OPU_EVT_OFS: rdata_reg <= {16'h0000, opu_evt_reg};
        OPU_ENA_OFS: rdata_reg <= {16'h0000, opu_ena_reg};
        OPS_EVT_OFS: rdata_reg <= {16'h0000, ops_evt_reg};
        OPS_ENA_OFS: rdata_reg <= {16'h0000, ops_ena_reg};
        QST_EVT_OFS: rdata_reg <= {16'h0000, qst_evt_reg};
        QST_ENA_OFS: rdata_reg <= {16'h0000, qst_ena_reg};
        SUMMARY_OFS: rdata_reg <= {29'h0, o_quest_summary, o_opr_summary, o_std_summary};
        default:     rdata_reg <= 32'h0000_0000;
      endcase
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata  = rdata_reg;
  assign o_s_axi_rresp  = rresp_reg;

  // ---------------- power-on flag ----------------
  // held until the first read of the standard flags, so it also survives a clear-all
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pon_pending_reg <= 1'b1;
    end else if (rd_fire && i_s_axi_araddr == STD_EVT_OFS) begin
      pon_pending_reg <= 1'b0;
    end
  end

  // ---------------- flag registers: set wins over read-clear, except the power-cycled bit ----------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      std_evt_reg <= STD_RESET;
    end else if ((rd_fire && i_s_axi_araddr == STD_EVT_OFS) || clear_all) begin
      std_evt_reg <= std_set & STD_MASK & ~(8'h80);
    end else begin
      std_evt_reg <= (std_evt_reg | std_set) & STD_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      opr_evt_reg <= WORD_RESET;
    end else if ((rd_fire && i_s_axi_araddr == OPR_EVT_OFS) || clear_all) begin
      // clear-all drops the rollup too, its source is cleared on the same edge
      opr_evt_reg <= clear_all ? WORD_RESET : (opr_set & OPR_MASK);
    end else begin
      opr_evt_reg <= (opr_evt_reg | opr_set) & OPR_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      opu_evt_reg <= WORD_RESET;
    end else if ((rd_fire && i_s_axi_araddr == OPU_EVT_OFS) || clear_all) begin
      opu_evt_reg <= clear_all ? WORD_RESET : (opu_set & OPU_MASK);
    end else begin
      opu_evt_reg <= (opu_evt_reg | opu_set) & OPU_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ops_evt_reg <= WORD_RESET;
    end else if ((rd_fire && i_s_axi_araddr == OPS_EVT_OFS) || clear_all) begin
      ops_evt_reg <= ops_set & OPS_MASK;
    end else begin
      ops_evt_reg <= (ops_evt_reg | ops_set) & OPS_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      qst_evt_reg <= WORD_RESET;
    end else if ((rd_fire && i_s_axi_araddr == QST_EVT_OFS) || clear_all) begin
      qst_evt_reg <= qst_set & QST_MASK;
    end else begin
      qst_evt_reg <= (qst_evt_reg | qst_set) & QST_MASK;
    end
  end

  // ---------------- enable registers: whole-word writes only ----------------
  // byte strobes ignored on purpose; a partial enable word is never formed
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      std_ena_reg <= STD_RESET;
      opr_ena_reg <= WORD_RESET;
      opu_ena_reg <= WORD_RESET;
      ops_ena_reg <= WORD_RESET;
      qst_ena_reg <= WORD_RESET;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        STD_ENA_OFS: std_ena_reg <= w_data_reg[7:0];
        OPR_ENA_OFS: opr_ena_reg <= w_data_reg[15:0];
        OPU_ENA_OFS: opu_ena_reg <= w_data_reg[15:0];
        OPS_ENA_OFS: ops_ena_reg <= w_data_reg[15:0];
        QST_ENA_OFS: qst_ena_reg <= w_data_reg[15:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------- assertions ----------------
  never_ctrl_req_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    !std_evt_reg[CONTROL_REQUEST_BIT]) else $error("control request bit set");

  op_done_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_std_evt.operation_done |=> std_evt_reg[OPERATION_DONE_BIT])
    else $error("operation done lost");

  empty_read_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_std_evt.empty_read |=> std_evt_reg[EMPTY_READ_BIT]) else $error("empty read lost");

  dev_fault_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_std_evt.internal_fault |=> std_evt_reg[INTERNAL_FAULT_BIT])
    else $error("internal fault lost");

  exec_fault_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_std_evt.exec_fault |=> std_evt_reg[EXEC_FAULT_BIT])
    else $error("execution fault lost");

  cmd_fault_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_std_evt.syntax_fault || i_std_evt.semantic_fault || i_std_evt.trigger_in_message)
    |=> std_evt_reg[COMMAND_FAULT_BIT]) else $error("command fault not flagged");

  user_req_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_std_evt.user_request |=> std_evt_reg[USER_REQUEST_BIT])
    else $error("user request lost");

  flag_latch_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (std_evt_reg[INTERNAL_FAULT_BIT] && !(rd_fire && i_s_axi_araddr == STD_EVT_OFS) && !clear_all)
    |=> std_evt_reg[INTERNAL_FAULT_BIT]) else $error("flag did not latch");

  read_clear_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (rd_fire && i_s_axi_araddr == OPS_EVT_OFS && ops_set == 16'h0000)
    |=> ops_evt_reg == 16'h0000 ##0 o_s_axi_rvalid) else $error("read did not clear");

  meas_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_cond.measuring |=> ops_evt_reg[MEAS_BIT]) else $error("measuring flag lost");

  trig_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_cond.wait_trigger |=> ops_evt_reg[TRIG_BIT]) else $error("trigger wait flag lost");

  filter_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_cond.filter_ready |=> ops_evt_reg[FILTER_BIT]) else $error("filter flag lost");

  idle_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_cond.idle |=> ops_evt_reg[IDLE_BIT]) else $error("idle flag lost");

  unit_summary_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (ops_evt_reg[MEAS_BIT] && ops_ena_reg[MEAS_BIT] && !clear_all)
    |=> opu_evt_reg[SUMMARY_ROLLUP_BIT]) else $error("unit summary missed");

  unit_rollup_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (opu_evt_reg[SUMMARY_ROLLUP_BIT] && opu_ena_reg[SUMMARY_ROLLUP_BIT] && !clear_all)
    |=> opr_evt_reg[UNIT_ROLLUP_BIT]) else $error("operation rollup missed");

  quest_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    i_quest_unit_sum |=> qst_evt_reg[UNIT_ROLLUP_BIT]) else $error("questionable flag lost");

  unused_zero_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    ((opr_evt_reg & ~OPR_MASK) == 16'h0000) && ((ops_evt_reg & ~OPS_MASK) == 16'h0000))
    else $error("unused flag bit set");

  power_flag_a: assert property (@(posedge i_mclk)
    $fell(i_reset) |-> std_evt_reg == STD_RESET ##1 std_evt_reg[POWER_CYCLED_BIT])
    else $error("power flag not raised after reset");

  enable_write_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_fire && aw_addr_reg == QST_ENA_OFS) |=> qst_ena_reg == $past(w_data_reg[15:0]))
    else $error("enable word not written whole");

  summary_and_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_std_summary == |(std_evt_reg & std_ena_reg)) else $error("summary mismatch");

  quest_summary_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (qst_evt_reg[UNIT_ROLLUP_BIT] && qst_ena_reg[UNIT_ROLLUP_BIT]) == o_quest_summary)
    else $error("questionable summary mismatch");

endmodule

/* sim/tb_top.sv */
// self-checking testbench for the status event tree
`timescale 1ns/1ps
module tb_top
  import isetr_pkg::*;
;
  logic           i_mclk = 1'b0;
  logic           i_reset = 1'b1;
  isetr_std_evt_t i_std_evt = '0;
  isetr_cond_t    i_cond = '0;
  logic           i_quest_unit_sum = 1'b0;
  logic [7:0]     i_s_axi_awaddr = 8'h00;
  logic           i_s_axi_awvalid = 1'b0;
  logic           o_s_axi_awready;
  logic [31:0]    i_s_axi_wdata = 32'h0;
  logic [3:0]     i_s_axi_wstrb = 4'hf;
  logic           i_s_axi_wvalid = 1'b0;
  logic           o_s_axi_wready;
  logic [1:0]     o_s_axi_bresp;
  logic           o_s_axi_bvalid;
  logic           i_s_axi_bready = 1'b0;
  logic [7:0]     i_s_axi_araddr = 8'h00;
  logic           i_s_axi_arvalid = 1'b0;
  logic           o_s_axi_arready;
  logic [31:0]    o_s_axi_rdata;
  logic [1:0]     o_s_axi_rresp;
  logic           o_s_axi_rvalid;
  logic           i_s_axi_rready = 1'b0;
  logic           o_std_summary;
  logic           o_opr_summary;
  logic           o_quest_summary;
  int             mismatches = 0;
  int             compares = 0;
  int             cycles = 0;
  logic [31:0]    d;

  isetr_event_tree isetr_event_tree_i (
    .i_mclk           (i_mclk),
    .i_reset          (i_reset),
    .i_std_evt        (i_std_evt),
    .i_cond           (i_cond),
    .i_quest_unit_sum (i_quest_unit_sum),
    .i_s_axi_awaddr   (i_s_axi_awaddr),
    .i_s_axi_awvalid  (i_s_axi_awvalid),
    .o_s_axi_awready  (o_s_axi_awready),
    .i_s_axi_wdata    (i_s_axi_wdata),
    .i_s_axi_wstrb    (i_s_axi_wstrb),
    .i_s_axi_wvalid   (i_s_axi_wvalid),
    .o_s_axi_wready   (o_s_axi_wready),
    .o_s_axi_bresp    (o_s_axi_bresp),
    .o_s_axi_bvalid   (o_s_axi_bvalid),
    .i_s_axi_bready   (i_s_axi_bready),
    .i_s_axi_araddr   (i_s_axi_araddr),
    .i_s_axi_arvalid  (i_s_axi_arvalid),
    .o_s_axi_arready  (o_s_axi_arready),
    .o_s_axi_rdata    (o_s_axi_rdata),
    .o_s_axi_rresp    (o_s_axi_rresp),
    .o_s_axi_rvalid   (o_s_axi_rvalid),
    .i_s_axi_rready   (i_s_axi_rready),
    .o_std_summary    (o_std_summary),
    .o_opr_summary    (o_opr_summary),
    .o_quest_summary  (o_quest_summary)
  );

  always #20 i_mclk = ~i_mclk;

  // generous ceiling, the run needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles > 4000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // entry waits one edge so ready lines never get two assignments in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    @(posedge i_mclk);
    i_s_axi_awaddr  <= a;
    i_s_axi_wdata   <= v;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid  <= 1'b1;
    i_s_axi_bready  <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge i_mclk);
      if (!aw_done && o_s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        i_s_axi_awvalid <= 1'b0;
      end
      if (!w_done && o_s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        i_s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge i_mclk); while (o_s_axi_bvalid !== 1'b1);
    check({30'h0, o_s_axi_bresp}, {30'h0, er}, "write response");
    i_s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge i_mclk);
    i_s_axi_araddr  <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready  <= 1'b1;
    do @(posedge i_mclk); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_mclk); while (o_s_axi_rvalid !== 1'b1);
    v = o_s_axi_rdata;
    check({30'h0, o_s_axi_rresp}, {30'h0, er}, "read response");
    i_s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] e, input logic [6:0] c, input logic q);
    i_std_evt        <= isetr_std_evt_t'(e);
    i_cond           <= isetr_cond_t'(c);
    i_quest_unit_sum <= q;
    @(posedge i_mclk);
    i_std_evt        <= '0;
    i_cond           <= '0;
    i_quest_unit_sum <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
  endtask

  // one event input per row and one condition input in every row but the last, with the flags they give
  logic [7:0]  t_evt[8]  = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
  logic [6:0]  t_cond[8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h00};
  logic [7:0]  t_std[8]  = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h20, 8'h20, 8'h40};
  logic [15:0] t_ops[8]  = '{16'h0001, 16'h0010, 16'h0020, 16'h0040,
                             16'h0100, 16'h0200, 16'h0400, 16'h0000};

  initial begin
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    rd(STD_EVT_OFS, RESP_OKAY, d); check(d, 32'h80, "power flag");
    rd(STD_EVT_OFS, RESP_OKAY, d); check(d, 32'h00, "std after read");
    rd(OPS_ENA_OFS, RESP_OKAY, d); check(d, 32'h0, "enable at reset");
    for (int i = 0; i < 8; i++) begin
      pulse(t_evt[i], t_cond[i], 1'b0);
      repeat (2) @(posedge i_mclk);
      rd(STD_EVT_OFS, RESP_OKAY, d); check(d, {24'h0, t_std[i]}, "std row");
      rd(OPS_EVT_OFS, RESP_OKAY, d); check(d, {16'h0, t_ops[i]}, "ops row");
      rd(STD_EVT_OFS, RESP_OKAY, d); check(d, 32'h0, "std cleared");
    end
    // every input at once, unused positions must stay low
    pulse(8'hff, 7'h7f, 1'b1);
    rd(STD_EVT_OFS, RESP_OKAY, d); check(d, 32'h7d, "all std");
    rd(OPS_EVT_OFS, RESP_OKAY, d); check(d, 32'h0771, "all ops");
    rd(OPU_EVT_OFS, RESP_OKAY, d); check(d, 32'h0, "unit disabled");
    rd(OPR_EVT_OFS, RESP_OKAY, d); check(d, 32'h0, "opr disabled");
    rd(QST_EVT_OFS, RESP_OKAY, d); check(d, 32'h2000, "quest flag");
    // std summary follows flag and enable
    wr(STD_ENA_OFS, 32'h08, RESP_OKAY);
    pulse(8'h20, 7'h00, 1'b0);
    check({31'h0, o_std_summary}, 32'h1, "std summary on");
    wr(STD_ENA_OFS, 32'h0, RESP_OKAY);
    check({31'h0, o_std_summary}, 32'h0, "std summary off");
    wr(STD_ENA_OFS, 32'h08, RESP_OKAY);
    rd(SUMMARY_OFS, RESP_OKAY, d); check(d, 32'h1, "summary reg std");
    rd(STD_EVT_OFS, RESP_OKAY, d); check(d, 32'h08, "fault flag");
    check({31'h0, o_std_summary}, 32'h0, "std summary cleared");
    // enable stores the whole word
    wr(OPU_ENA_OFS, 32'hffff, RESP_OKAY);
    rd(OPU_ENA_OFS, RESP_OKAY, d); check(d, 32'hffff, "whole enable");
    // rollup chain from summary flags to operation summary
    wr(OPS_ENA_OFS, 32'h0010, RESP_OKAY);
    wr(OPU_ENA_OFS, 32'h0002, RESP_OKAY);
    wr(OPR_ENA_OFS, 32'h2000, RESP_OKAY);
    pulse(8'h00, 7'h20, 1'b0);
    repeat (3) @(posedge i_mclk);
    check({31'h0, o_opr_summary}, 32'h1, "opr summary");
    rd(SUMMARY_OFS, RESP_OKAY, d); check(d, 32'h2, "summary reg op");
    rd(OPR_EVT_OFS, RESP_OKAY, d); check(d, 32'h2000, "opr rollup");
    rd(OPU_EVT_OFS, RESP_OKAY, d); check(d, 32'h0002, "unit rollup");
    rd(OPS_EVT_OFS, RESP_OKAY, d); check(d, 32'h0010, "meas flag");
    wr(CLEAR_ALL_OFS, 32'h1, RESP_OKAY);
    repeat (3) @(posedge i_mclk);
    check({31'h0, o_opr_summary}, 32'h0, "opr after clear");
    // questionable summary
    wr(QST_ENA_OFS, 32'h2000, RESP_OKAY);
    pulse(8'h00, 7'h00, 1'b1);
    check({31'h0, o_quest_summary}, 32'h1, "quest summary");
    rd(SUMMARY_OFS, RESP_OKAY, d); check(d, 32'h4, "summary reg q");
    // unmapped and unaligned places answer with an error
    rd(8'h30, RESP_SLVERR, d); check(d, 32'h0, "unmapped read");
    rd(8'h02, RESP_SLVERR, d); check(d, 32'h0, "unaligned read");
    wr(8'h30, 32'hffff, RESP_SLVERR);
    // second reset in mid-run
    @(posedge i_mclk);
    do_reset();
    rd(STD_EVT_OFS, RESP_OKAY, d); check(d, 32'h80, "power again");
    rd(QST_ENA_OFS, RESP_OKAY, d); check(d, 32'h0, "enable cleared");
    rd(QST_EVT_OFS, RESP_OKAY, d); check(d, 32'h0, "quest cleared");
    finish_test();
  end
endmodule
